// ==== rtcs_pkg.sv ====
/*
 * rtcs_pkg: constants for the two-wire register access slave.
 * assumes one 32-entry byte array behind the serial port.
 */
`default_nettype none
package rtcs_pkg;
    // device identifier, value is arbitrary
    localparam logic [6:0] RTCS_DEV_ID = 7'h2a;
    localparam int RTCS_REGS = 32;
    localparam logic [7:0] RTCS_PTR_TOP = 8'h1f;
    localparam logic [7:0] RTCS_PTR_RST = 8'h00;
    localparam logic [7:0] RTCS_MEM_RST = 8'h00;
    localparam logic [3:0] RTCS_BIT_LAST = 4'h8;
    localparam logic [3:0] RTCS_TX_LAST = 4'h7;
    localparam logic [3:0] RTCS_CNT_RST = 4'h0;
    localparam int RTCS_PWRUP_CYC = 16;
    typedef enum logic [2:0] {
        RTCS_S_IDLE,
        RTCS_S_DEV,
        RTCS_S_REG,
        RTCS_S_WR,
        RTCS_S_RD,
        RTCS_S_MACK,
        RTCS_S_IGN
    } rtcs_state_t;
endpackage : rtcs_pkg
`default_nettype wire

// ==== rtcs_slave.sv ====
/*
 * rtcs_slave: two-wire serial slave giving a bus master byte access
 * to a 32-entry register array, plus a core-side update port.
 * assumes scl/sda pins are asynchronous, the link clock is free running
 * and several times faster than scl, and sda is open drain outside.
 */
// Notes on behaviour
// - respond only after a detected start
// - ignore start during power-up; sda released
// - stop returns slave to idle standby
// - every byte shifted msb first
// - sender releases; receiver acks ninth clock
// - acknowledge only on matching identifier
// - address lsb selects read or write
// - second write byte loads the pointer
// - pointer cleared to zero at power-up
// - write: address, register, data, all acked
// - ack and store each received data byte
// - keep sending while master acknowledges
// - read from pointer, increment per byte
// - pointer wraps from top to zero
`timescale 1ns/1ns
`default_nettype none
module rtcs_slave
    import rtcs_pkg::*;
#(
    parameter int PWRUP_CYC = RTCS_PWRUP_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_n_in,
    input wire logic link_clk_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic upd_valid_in,
    output logic upd_ready_out,
    input wire logic [4:0] upd_addr_in,
    input wire logic [7:0] upd_data_in,
    output logic wr_event_out,
    output logic [4:0] wr_addr_out,
    output logic [7:0] wr_data_out
);
    initial begin
        if (PWRUP_CYC < 1 || PWRUP_CYC > 65535) begin
            $error("PWRUP_CYC out of range");
        end
    end

    localparam logic [15:0] PWR_LAST = 16'(PWRUP_CYC - 1);

    // ---- link domain: pin synchronisers ----
    logic scl_meta_q, scl_sync_q, scl_prev_q, sda_meta_q, sda_sync_q, sda_prev_q;
    logic scl_meta_d, scl_sync_d, scl_prev_d, sda_meta_d, sda_sync_d, sda_prev_d;
    logic scl_rise, scl_fall, start_det, stop_det;

    always_comb begin
        scl_meta_d = scl_in;
        scl_sync_d = scl_meta_q;
        scl_prev_d = scl_sync_q;
        sda_meta_d = sda_in;
        sda_sync_d = sda_meta_q;
        sda_prev_d = sda_sync_q;
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_meta_q <= 1'b1;
            scl_sync_q <= 1'b1;
            scl_prev_q <= 1'b1;
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_meta_q <= scl_meta_d;
            scl_sync_q <= scl_sync_d;
            scl_prev_q <= scl_prev_d;
            sda_meta_q <= sda_meta_d;
            sda_sync_q <= sda_sync_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    assign scl_rise = scl_sync_q && !scl_prev_q;
    assign scl_fall = !scl_sync_q && scl_prev_q;
    // sda moving under a steady high scl marks start or stop
    assign start_det = scl_sync_q && scl_prev_q && sda_prev_q && !sda_sync_q;
    assign stop_det = scl_sync_q && scl_prev_q && !sda_prev_q && sda_sync_q;

    // ---- link domain: power-up hold-off ----
    logic [15:0] pwr_cnt_q, pwr_cnt_d;
    logic pwr_done_q, pwr_done_d;

    always_comb begin
        pwr_cnt_d = pwr_cnt_q;
        pwr_done_d = pwr_done_q;
        if (!pwr_done_q) begin
            if (pwr_cnt_q == PWR_LAST) begin
                pwr_done_d = 1'b1;
            end else begin
                pwr_cnt_d = pwr_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pwr_cnt_q <= 16'h0000;
            pwr_done_q <= 1'b0;
        end else begin
            pwr_cnt_q <= pwr_cnt_d;
            pwr_done_q <= pwr_done_d;
        end
    end

    // ---- link domain: protocol engine and array ----
    rtcs_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d;
    logic ack_q, ack_d, rw_q, rw_d, mack_q, mack_d, drive_q, drive_d;
    logic [7:0] mem_q [RTCS_REGS];
    logic [7:0] mem_d [RTCS_REGS];
    logic [4:0] wl_addr_q, wl_addr_d;
    logic [7:0] wl_data_q, wl_data_d;
    logic wl_tgl_q, wl_tgl_d, useen_q, useen_d, i2c_wr;
    logic ureq_meta_q, ureq_sync_q;
    logic [4:0] uaddr_q;
    logic [7:0] udata_q;
    logic ureq_q;

    function automatic logic [7:0] ptr_next(input logic [7:0] p);
        ptr_next = (p >= RTCS_PTR_TOP) ? RTCS_PTR_RST : p + 8'h01;
    endfunction : ptr_next

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        ack_d = ack_q;
        rw_d = rw_q;
        mack_d = mack_q;
        mem_d = mem_q;
        wl_addr_d = wl_addr_q;
        wl_data_d = wl_data_q;
        wl_tgl_d = wl_tgl_q;
        useen_d = useen_q;
        i2c_wr = 1'b0;
        if (!pwr_done_q) begin
            st_d = RTCS_S_IDLE;
        end else if (start_det) begin
            st_d = RTCS_S_DEV;
            cnt_d = RTCS_CNT_RST;
            ack_d = 1'b0;
        end else if (stop_det) begin
            st_d = RTCS_S_IDLE;
            ack_d = 1'b0;
        end else begin
            case (st_q)
                RTCS_S_DEV, RTCS_S_REG, RTCS_S_WR: begin
                    if (ack_q) begin
                        if (scl_fall) begin
                            ack_d = 1'b0;
                            cnt_d = RTCS_CNT_RST;
                            if (st_q == RTCS_S_DEV && rw_q) begin
                                st_d = RTCS_S_RD;
                                tx_d = mem_q[ptr_q[4:0]];
                            end else if (st_q == RTCS_S_DEV) begin
                                st_d = RTCS_S_REG;
                            end else begin
                                st_d = RTCS_S_WR;
                            end
                        end
                    end else if (scl_rise && cnt_q != RTCS_BIT_LAST) begin
                        sh_d = {sh_q[6:0], sda_sync_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == RTCS_BIT_LAST) begin
                        if (st_q == RTCS_S_DEV) begin
                            if (sh_q[7:1] == RTCS_DEV_ID) begin
                                ack_d = 1'b1;
                                rw_d = sh_q[0];
                            end else begin
                                st_d = RTCS_S_IGN;
                            end
                        end else if (st_q == RTCS_S_REG) begin
                            ptr_d = sh_q;
                            ack_d = 1'b1;
                        end else begin
                            mem_d[ptr_q[4:0]] = sh_q;
                            i2c_wr = 1'b1;
                            wl_addr_d = ptr_q[4:0];
                            wl_data_d = sh_q;
                            wl_tgl_d = ~wl_tgl_q;
                            ptr_d = ptr_next(ptr_q);
                            ack_d = 1'b1;
                        end
                    end
                end
                RTCS_S_RD: begin
                    if (scl_fall) begin
                        if (cnt_q == RTCS_TX_LAST) begin
                            st_d = RTCS_S_MACK;
                            mack_d = 1'b0;
                            ptr_d = ptr_next(ptr_q);
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            cnt_d = cnt_q + 4'h1;
                        end
                    end
                end
                RTCS_S_MACK: begin
                    if (scl_rise) begin
                        mack_d = !sda_sync_q;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            st_d = RTCS_S_RD;
                            tx_d = mem_q[ptr_q[4:0]];
                            cnt_d = RTCS_CNT_RST;
                        end else begin
                            st_d = RTCS_S_IGN;
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (ureq_sync_q != useen_q && !i2c_wr) begin
            mem_d[uaddr_q] = udata_q;
            useen_d = ~useen_q;
        end
        drive_d = ack_d || (st_d == RTCS_S_RD && !tx_d[7]);
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= RTCS_S_IDLE;
            cnt_q <= RTCS_CNT_RST;
            sh_q <= RTCS_MEM_RST;
            tx_q <= RTCS_MEM_RST;
            ptr_q <= RTCS_PTR_RST;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            mack_q <= 1'b0;
            drive_q <= 1'b0;
            wl_addr_q <= 5'h00;
            wl_data_q <= RTCS_MEM_RST;
            wl_tgl_q <= 1'b0;
            useen_q <= 1'b0;
            ureq_meta_q <= 1'b0;
            ureq_sync_q <= 1'b0;
            for (int i = 0; i < RTCS_REGS; i++) begin
                mem_q[i] <= RTCS_MEM_RST;
            end
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            ack_q <= ack_d;
            rw_q <= rw_d;
            mack_q <= mack_d;
            drive_q <= drive_d;
            wl_addr_q <= wl_addr_d;
            wl_data_q <= wl_data_d;
            wl_tgl_q <= wl_tgl_d;
            useen_q <= useen_d;
            ureq_meta_q <= ureq_q;
            ureq_sync_q <= ureq_meta_q;
            mem_q <= mem_d;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = drive_q;

    // ---- core domain: update port and write notification ----
    logic [4:0] uaddr_d, wr_addr_d;
    logic [7:0] udata_d, wr_data_d;
    logic ureq_d, uack_meta_q, uack_sync_q, wt_meta_q, wt_sync_q, wt_prev_q;
    logic wr_event_q, wr_event_d;
    logic [4:0] wr_addr_q;
    logic [7:0] wr_data_q;

    assign upd_ready_out = (uack_sync_q == ureq_q);

    always_comb begin
        uaddr_d = uaddr_q;
        udata_d = udata_q;
        ureq_d = ureq_q;
        wr_addr_d = wr_addr_q;
        wr_data_d = wr_data_q;
        wr_event_d = 1'b0;
        if (upd_valid_in && upd_ready_out) begin
            uaddr_d = upd_addr_in;
            udata_d = upd_data_in;
            ureq_d = ~ureq_q;
        end
        if (wt_sync_q != wt_prev_q) begin
            wr_addr_d = wl_addr_q;
            wr_data_d = wl_data_q;
            wr_event_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            uaddr_q <= 5'h00;
            udata_q <= RTCS_MEM_RST;
            ureq_q <= 1'b0;
            uack_meta_q <= 1'b0;
            uack_sync_q <= 1'b0;
            wt_meta_q <= 1'b0;
            wt_sync_q <= 1'b0;
            wt_prev_q <= 1'b0;
            wr_addr_q <= 5'h00;
            wr_data_q <= RTCS_MEM_RST;
            wr_event_q <= 1'b0;
        end else begin
            uaddr_q <= uaddr_d;
            udata_q <= udata_d;
            ureq_q <= ureq_d;
            uack_meta_q <= useen_q;
            uack_sync_q <= uack_meta_q;
            wt_meta_q <= wl_tgl_q;
            wt_sync_q <= wt_meta_q;
            wt_prev_q <= wt_sync_q;
            wr_addr_q <= wr_addr_d;
            wr_data_q <= wr_data_d;
            wr_event_q <= wr_event_d;
        end
    end

    assign wr_event_out = wr_event_q;
    assign wr_addr_out = wr_addr_q;
    assign wr_data_out = wr_data_q;

    // ---- checks, link domain ----
    sequence seq_byte_in(rtcs_state_t s);
        st_q == s && !ack_q && scl_fall && cnt_q == RTCS_BIT_LAST;
    endsequence

    chk_pwrup_quiet: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        !pwr_done_q |=> st_q == RTCS_S_IDLE && !sda_oe_out)
        else $error("start taken or sda driven during power-up");
    chk_start_enter: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        pwr_done_q && start_det |=> st_q == RTCS_S_DEV && cnt_q == RTCS_CNT_RST)
        else $error("start not followed by address phase");
    chk_stop_idle: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        pwr_done_q && stop_det |=> st_q == RTCS_S_IDLE ##1 !sda_oe_out)
        else $error("stop did not return to idle");
    chk_id_ack: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        (pwr_done_q && sh_q[7:1] == RTCS_DEV_ID) and seq_byte_in(RTCS_S_DEV)
        |=> ack_q ##1 sda_oe_out)
        else $error("matching identifier not acknowledged");
    chk_id_nack: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        (pwr_done_q && sh_q[7:1] != RTCS_DEV_ID) and seq_byte_in(RTCS_S_DEV)
        |=> st_q == RTCS_S_IGN ##1 !sda_oe_out)
        else $error("foreign identifier not ignored");
    chk_ptr_load: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        (pwr_done_q && !start_det && !stop_det) and seq_byte_in(RTCS_S_REG)
        |=> ptr_q == $past(sh_q) && ack_q)
        else $error("register address not loaded");
    chk_wr_store: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        (pwr_done_q && !start_det && !stop_det) and seq_byte_in(RTCS_S_WR)
        |=> mem_q[$past(ptr_q[4:0])] == $past(sh_q) && ptr_q == ptr_next($past(ptr_q)))
        else $error("write byte not stored or pointer not advanced");
    chk_rd_wrap: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        pwr_done_q && !start_det && !stop_det && st_q == RTCS_S_RD && scl_fall
        && cnt_q == RTCS_TX_LAST && ptr_q == RTCS_PTR_TOP
        |=> ptr_q == RTCS_PTR_RST && st_q == RTCS_S_MACK)
        else $error("pointer did not wrap after top location");
    chk_ack_release: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        ack_q && scl_fall && !start_det && !stop_det |=> !ack_q)
        else $error("acknowledge held past ninth clock");
    chk_rd_msb: assert property (@(posedge link_clk_in) disable iff (!rst_n_in)
        pwr_done_q && !start_det && !stop_det && st_q == RTCS_S_DEV && ack_q && rw_q
        && scl_fall |=> st_q == RTCS_S_RD ##1 sda_oe_out == !$past(tx_q[7]))
        else $error("read byte not started msb first");
endmodule : rtcs_slave
`default_nettype wire

// ==== rtcs_bus_master.sv ====
/*
 * rtcs_bus_master: behavioural two-wire bus master for the slave bench.
 * assumes sda is resolved outside with a pull-up; each task except stop_c ends with scl low.
 */
`timescale 1ns/1ns
`default_nettype none
module rtcs_bus_master (
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_oe_out
);
    int hp = 300;
    initial begin
        scl_out = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic start_c();
        sda_oe_out = 1'b0;
        #(hp / 2) scl_out = 1'b1;
        #(hp) sda_oe_out = 1'b1;
        #(hp) scl_out = 1'b0;
        #(hp / 2);
    endtask : start_c
    task automatic stop_c();
        sda_oe_out = 1'b1;
        #(hp / 2) scl_out = 1'b1;
        #(hp) sda_oe_out = 1'b0;
        #(hp);
    endtask : stop_c
    // sda set mid low phase, sampled mid high phase
    task automatic bit_c(input logic b, output logic r);
        sda_oe_out = ~b;
        #(hp / 2) scl_out = 1'b1;
        #(hp / 2) r = sda_in;
        #(hp / 2) scl_out = 1'b0;
        #(hp / 2);
    endtask : bit_c
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(d[i], r);
        bit_c(1'b1, r);
        ack = ~r;
    endtask : put_byte
    task automatic get_byte(output logic [7:0] d, input logic more);
        logic r;
        for (int i = 7; i >= 0; i--) bit_c(1'b1, d[i]);
        bit_c(~more, r);
    endtask : get_byte
endmodule : rtcs_bus_master
`default_nettype wire

// ==== tb_rtcs_slave.sv ====
/*
 * tb_rtcs_slave: random and corner tests of the two-wire register slave.
 * assumes rtcs_pkg, rtcs_slave and rtcs_bus_master are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_rtcs_slave;
    import rtcs_pkg::*;
    logic mclk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic upd_valid = 1'b0;
    logic [4:0] upd_addr = 5'h00;
    logic [7:0] upd_data = 8'h00;
    logic scl, m_oe, sda, sda_o, sda_oe, upd_ready, wr_event;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] exp_mem [32];
    logic [7:0] ptr;
    logic [12:0] gotq [$];
    logic [12:0] expq [$];
    int miscompares = 0;
    int checks_done = 0;
    always #5 mclk = ~mclk;
    initial begin
        #2;
        forever #15 link_clk = ~link_clk;
    end
    assign sda = !(m_oe || (sda_oe && !sda_o));
    rtcs_slave #(.PWRUP_CYC(40)) u_rtcs_slave (.mclk_in(mclk), .rst_n_in(rst_n),
        .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .upd_valid_in(upd_valid), .upd_ready_out(upd_ready),
        .upd_addr_in(upd_addr), .upd_data_in(upd_data), .wr_event_out(wr_event),
        .wr_addr_out(wr_addr), .wr_data_out(wr_data));
    rtcs_bus_master u_rtcs_bus_master (.sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));
    always @(posedge mclk) if (wr_event === 1'b1) gotq.push_back({wr_addr, wr_data});
    function automatic logic [7:0] nxt(input logic [7:0] p);
        return (p >= RTCS_PTR_TOP) ? 8'h00 : p + 8'h01;
    endfunction : nxt
    task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic results();
        if (miscompares == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    task automatic upd(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        upd_valid <= 1'b1;
        upd_addr <= a;
        upd_data <= d;
        do @(negedge mclk); while (upd_ready !== 1'b1);
        @(posedge mclk);
        upd_valid <= 1'b0;
        exp_mem[a] = d;
        repeat (4) @(posedge mclk);
    endtask : upd
    task automatic addr_ph(input logic rd);
        logic a;
        u_rtcs_bus_master.start_c();
        u_rtcs_bus_master.put_byte({RTCS_DEV_ID, rd}, a);
        chk(13'(a), 13'h1);
    endtask : addr_ph
    task automatic drain();
        repeat (30) @(posedge mclk);
        chk(13'(gotq.size()), 13'(expq.size()));
        while (expq.size() > 0 && gotq.size() > 0) chk(gotq.pop_front(), expq.pop_front());
        gotq.delete();
        expq.delete();
    endtask : drain
    task automatic bus_wr(input logic [7:0] ra, input int n);
        logic a;
        logic [7:0] d;
        addr_ph(1'b0);
        u_rtcs_bus_master.put_byte(ra, a);
        chk(13'(a), 13'h1);
        ptr = ra;
        for (int k = 0; k < n; k++) begin
            d = 8'($urandom);
            u_rtcs_bus_master.put_byte(d, a);
            chk(13'(a), 13'h1);
            exp_mem[ptr[4:0]] = d;
            expq.push_back({ptr[4:0], d});
            ptr = nxt(ptr);
        end
        u_rtcs_bus_master.stop_c();
        drain();
    endtask : bus_wr
    task automatic bus_rd(input logic rnd, input logic [7:0] ra, input int n);
        logic a;
        logic [7:0] d;
        if (rnd) begin
            addr_ph(1'b0);
            u_rtcs_bus_master.put_byte(ra, a);
            chk(13'(a), 13'h1);
            ptr = ra;
        end
        addr_ph(1'b1);
        for (int k = 0; k < n; k++) begin
            u_rtcs_bus_master.get_byte(d, k < n - 1);
            chk(13'(d), 13'(exp_mem[ptr[4:0]]));
            ptr = nxt(ptr);
        end
        u_rtcs_bus_master.stop_c();
    endtask : bus_rd
    initial begin
        #1_000_000;
        miscompares++;
        results();
    end
    initial begin
        logic a;
        void'($urandom(1));
        for (int i = 0; i < 32; i++) exp_mem[i] = RTCS_MEM_RST;
        ptr = RTCS_PTR_RST;
        repeat (2) @(posedge mclk);
        chk(13'(sda_oe), 13'h0);
        rst_n <= 1'b1;
        // start while still powering up
        u_rtcs_bus_master.start_c();
        u_rtcs_bus_master.put_byte({RTCS_DEV_ID, 1'b0}, a);
        chk(13'(a), 13'h0);
        u_rtcs_bus_master.stop_c();
        upd(5'h00, 8'($urandom));
        bus_rd(1'b0, 8'h00, 2);
        // foreign identifier, then a byte that must be ignored
        u_rtcs_bus_master.start_c();
        u_rtcs_bus_master.put_byte({RTCS_DEV_ID ^ 7'h01, 1'b0}, a);
        chk(13'(a), 13'h0);
        u_rtcs_bus_master.put_byte(8'h03, a);
        chk(13'(a), 13'h0);
        u_rtcs_bus_master.stop_c();
        drain();
        bus_wr(8'h1e, 3);
        bus_rd(1'b1, 8'h1f, 3);
        u_rtcs_bus_master.hp = 700;
        bus_wr(8'(RTCS_PTR_TOP), 2);
        bus_rd(1'b1, 8'h1e, 4);
        u_rtcs_bus_master.hp = 300;
        for (int i = 0; i < 5; i++) begin
            upd(5'($urandom), 8'($urandom));
            bus_wr(8'($urandom_range(31)), 1 + $urandom_range(2));
            bus_rd(1'($urandom), 8'($urandom_range(31)), 1 + $urandom_range(2));
        end
        results();
    end
endmodule : tb_rtcs_slave
`default_nettype wire
